// *** verilog/sff_front_end.sv ***
// Serial flash bus front end: opcode, address, dummy and read data phases
//
// Operation
// - Link is clock, active-low select, data into device, data out.
// - Device works with host clock mode 0 or mode 3.
// - Input data captured on every rising serial clock edge.
// - Output data changes only on falling serial clock edges in the data phase.
// - Opcodes 3Bh and BBh transfer over two lines.
// - In dual transfers input and output pins are both bidirectional lines.
// - Dual output read drives data on both input and output pins.
// - Single-line reads 03h and 0Bh drive only the output pin.
// - Opcode EBh transfers address and data over four lines.
// - Sectors are 4 KB aligned; sector 15 is 00F000h to 00FFFFh.
// - Sector 1023 spans 3FF000h to 3FFFFFh; indices are upper address bits.
// - In four-line transfers protect and hold pins are lines two, three.
`timescale 1ns/10ps
module sff_front_end
    import sff_pkg::*;
(
    input  wire logic                clock_i,
    input  wire logic                sys_rst_i,
    input  wire logic                sclk_i,
    input  wire logic                cs_n_i,
    input  wire logic                io_line_zero_i,
    output logic                     io_line_zero_o,
    output logic                     io_line_zero_oe_o,
    input  wire logic                io_line_one_i,
    output logic                     io_line_one_o,
    output logic                     io_line_one_oe_o,
    input  wire logic                io_line_two_i,
    output logic                     io_line_two_o,
    output logic                     io_line_two_oe_o,
    input  wire logic                io_line_three_i,
    output logic                     io_line_three_o,
    output logic                     io_line_three_oe_o,
    output logic [7:0]               cmd_o,
    output logic                     cmd_valid_o,
    output logic [7:0]               rx_byte_o,
    output logic                     rx_valid_o,
    output logic                     addr_valid_o,
    output logic [sff_pkg::ADDR_W-1:0]   rd_addr_o,
    output logic                     rd_strobe_o,
    input  wire logic [7:0]          rd_data_i,
    output logic [sff_pkg::SECTOR_W-1:0] sector_o,
    output logic [sff_pkg::HALF_W-1:0]   half_block_o,
    output logic [sff_pkg::BLOCK_W-1:0]  block_o,
    output logic                     in_low_range_o
);
    import sff_pkg::*;

    sff_pin_if pin ();

    sff_pin_sampler sff_pin_sampler_i (
        .clock_i   (clock_i),
        .sys_rst_i (sys_rst_i),
        .sclk_i    (sclk_i),
        .cs_n_i    (cs_n_i),
        .din_i     ({io_line_three_i, io_line_two_i, io_line_one_i, io_line_zero_i}),
        .pin       (pin.sampler)
    );

    ////////////////////////////////////////////////////////////////////////
    // State

    sff_state_t          state_q;
    sff_state_t          state_d;
    logic [4:0]          cnt_q;
    logic [4:0]          cnt_d;
    logic [23:0]         sh_q;
    sff_lanes_t          lanes_q;
    sff_lanes_t          lanes_d;
    sff_lanes_t          data_lanes_q;
    sff_lanes_t          data_lanes_d;
    logic [4:0]          dummy_q;
    logic [4:0]          dummy_d;
    logic [ADDR_W-1:0]   addr_q;
    logic [7:0]          tx_q;
    logic [2:0]          ocnt_q;

    ////////////////////////////////////////////////////////////////////////
    // Decode

    logic [23:0] sh_nx;
    logic [7:0]  op_nx;
    logic [4:0]  addr_clks;
    logic        last_cmd;
    logic        last_addr;
    logic        last_dummy;
    logic        last_rx;
    logic        is_read;
    logic        cmd_done;
    logic        addr_done;
    logic        rx_done;
    logic        in_data;
    logic        byte_start;
    logic [7:0]  src;

    // MSB first; lane 3 holds the highest bit of each four-line group, lane 1 of each two-line group
    assign sh_nx = (lanes_q == LANES_4) ? {sh_q[19:0], pin.din} :
                   (lanes_q == LANES_2) ? {sh_q[21:0], pin.din[1:0]} :
                                          {sh_q[22:0], pin.din[0]};
    assign op_nx     = sh_nx[7:0];
    assign addr_clks = (lanes_q == LANES_4) ? ADDR_CLKS_X4 :
                       (lanes_q == LANES_2) ? ADDR_CLKS_X2 : ADDR_CLKS_X1;
    assign last_cmd   = cnt_q == CMD_CLKS - 5'h01;
    assign last_rx    = cnt_q == CMD_CLKS - 5'h01;
    assign last_addr  = cnt_q == addr_clks - 5'h01;
    assign last_dummy = cnt_q == dummy_q - 5'h01;
    assign is_read    = (op_nx == OP_READ) || (op_nx == OP_FAST_READ) ||
                        (op_nx == OP_DUAL_OUT) || (op_nx == OP_DUAL_IO) ||
                        (op_nx == OP_QUAD_IO);
    assign cmd_done   = pin.rise && (state_q == ST_CMD) && last_cmd;
    assign addr_done  = pin.rise && (state_q == ST_ADDR) && last_addr;
    assign rx_done    = pin.rise && (state_q == ST_RX) && last_rx;
    assign in_data    = pin.fall && (state_q == ST_DATA);
    assign byte_start = ocnt_q == 3'h0;
    assign src        = byte_start ? rd_data_i : tx_q;

    // Opcode selects lane widths and dummy length
    always_comb begin
        lanes_d      = LANES_1;
        data_lanes_d = LANES_1;
        dummy_d      = DUMMY_NONE;
        unique case (op_nx)
            OP_FAST_READ: begin
                dummy_d = DUMMY_FAST;
            end
            OP_DUAL_OUT: begin
                dummy_d      = DUMMY_FAST;
                data_lanes_d = LANES_2;
            end
            OP_DUAL_IO: begin
                lanes_d      = LANES_2;
                data_lanes_d = LANES_2;
                dummy_d      = DUMMY_DUAL_IO;
            end
            OP_QUAD_IO: begin
                lanes_d      = LANES_4;
                data_lanes_d = LANES_4;
                dummy_d      = DUMMY_QUAD_IO;
            end
            default: begin
                lanes_d      = LANES_1;
            end
        endcase
    end

    // Phase sequencing on rising serial clock edges
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        if (!pin.sel) begin
            state_d = ST_IDLE;
            cnt_d   = 5'h00;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    state_d = ST_CMD;
                end
                ST_CMD: begin
                    if (pin.rise) begin
                        cnt_d = last_cmd ? 5'h00 : cnt_q + 5'h01;
                        if (last_cmd) begin
                            state_d = is_read ? ST_ADDR : ST_RX;
                        end
                    end
                end
                ST_RX: begin
                    if (pin.rise) begin
                        cnt_d = last_rx ? 5'h00 : cnt_q + 5'h01;
                    end
                end
                ST_ADDR: begin
                    if (pin.rise) begin
                        cnt_d = last_addr ? 5'h00 : cnt_q + 5'h01;
                        if (last_addr) begin
                            state_d = (dummy_q == DUMMY_NONE) ? ST_DATA : ST_DUMMY;
                        end
                    end
                end
                ST_DUMMY: begin
                    if (pin.rise) begin
                        cnt_d = last_dummy ? 5'h00 : cnt_q + 5'h01;
                        if (last_dummy) begin
                            state_d = ST_DATA;
                        end
                    end
                end
                ST_DATA: begin
                    state_d = ST_DATA;
                end
                default: begin
                    state_d = ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            state_q <= ST_IDLE;
            cnt_q   <= 5'h00;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i || !pin.sel) begin
            sh_q <= 24'h000000;
        end else if (pin.rise) begin
            sh_q <= sh_nx;
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i || !pin.sel) begin
            lanes_q      <= LANES_1;
            data_lanes_q <= LANES_1;
            dummy_q      <= DUMMY_NONE;
        end else if (cmd_done) begin
            lanes_q      <= lanes_d;
            data_lanes_q <= data_lanes_d;
            dummy_q      <= dummy_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Received fields

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            cmd_o       <= BYTE_RST;
            cmd_valid_o <= 1'b0;
            rx_byte_o   <= BYTE_RST;
            rx_valid_o  <= 1'b0;
        end else begin
            cmd_valid_o <= cmd_done;
            rx_valid_o  <= rx_done;
            if (cmd_done) begin
                cmd_o <= op_nx;
            end
            if (rx_done) begin
                rx_byte_o <= sh_nx[7:0];
            end
        end
    end

    // Sector, half block and block are upper address bits
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            addr_valid_o   <= 1'b0;
            sector_o       <= '0;
            half_block_o   <= '0;
            block_o        <= '0;
            in_low_range_o <= 1'b0;
        end else begin
            addr_valid_o <= addr_done;
            if (addr_done) begin
                sector_o       <= sh_nx[RANGE_LSB-1:SECTOR_LSB];
                half_block_o   <= sh_nx[RANGE_LSB-1:HALF_LSB];
                block_o        <= sh_nx[RANGE_LSB-1:BLOCK_LSB];
                in_low_range_o <= sh_nx[ADDR_W-1:RANGE_LSB] == 2'b00;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data out on falling edges

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            addr_q      <= ADDR_RST;
            rd_strobe_o <= 1'b0;
        end else begin
            rd_strobe_o <= in_data && byte_start;
            if (addr_done) begin
                addr_q <= sh_nx;
            end else if (in_data && byte_start) begin
                addr_q <= addr_q + 24'h000001;
            end
        end
    end

    assign rd_addr_o = addr_q;

    always_ff @(posedge clock_i) begin
        if (sys_rst_i || !pin.sel) begin
            tx_q   <= BYTE_RST;
            ocnt_q <= 3'h0;
        end else if (in_data) begin
            unique case (data_lanes_q)
                LANES_4: begin
                    tx_q   <= {src[3:0], 4'h0};
                    ocnt_q <= byte_start ? OCNT_X4 : ocnt_q - 3'h1;
                end
                LANES_2: begin
                    tx_q   <= {src[5:0], 2'b00};
                    ocnt_q <= byte_start ? OCNT_X2 : ocnt_q - 3'h1;
                end
                default: begin
                    tx_q   <= {src[6:0], 1'b0};
                    ocnt_q <= byte_start ? OCNT_X1 : ocnt_q - 3'h1;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            io_line_zero_o  <= 1'b0;
            io_line_one_o   <= 1'b0;
            io_line_two_o   <= 1'b0;
            io_line_three_o <= 1'b0;
        end else if (in_data) begin
            io_line_three_o <= src[7];
            io_line_two_o   <= src[6];
            io_line_one_o   <= (data_lanes_q == LANES_4) ? src[5] : src[7];
            io_line_zero_o  <= (data_lanes_q == LANES_4) ? src[4] : src[6];
        end
    end

    always_ff @(posedge clock_i) begin
        if (sys_rst_i || !pin.sel) begin
            io_line_zero_oe_o  <= 1'b0;
            io_line_one_oe_o   <= 1'b0;
            io_line_two_oe_o   <= 1'b0;
            io_line_three_oe_o <= 1'b0;
        end else if (in_data) begin
            io_line_one_oe_o   <= 1'b1;
            io_line_zero_oe_o  <= data_lanes_q != LANES_1;
            io_line_two_oe_o   <= data_lanes_q == LANES_4;
            io_line_three_oe_o <= data_lanes_q == LANES_4;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    property p_float_deselected;
        @(posedge clock_i) disable iff (sys_rst_i)
        !pin.sel |=> !io_line_zero_oe_o && !io_line_one_oe_o &&
                     !io_line_two_oe_o && !io_line_three_oe_o;
    endproperty
    a_float_deselected: assert property (p_float_deselected)
        else $error("data pin driven while deselected");

    property p_change_on_fall;
        @(posedge clock_i) disable iff (sys_rst_i)
        $changed(io_line_one_o) |-> $past(pin.fall);
    endproperty
    a_change_on_fall: assert property (p_change_on_fall)
        else $error("output changed without a falling clock edge");

    property p_single_line;
        @(posedge clock_i) disable iff (sys_rst_i)
        io_line_one_oe_o && (data_lanes_q == LANES_1) |->
            !io_line_zero_oe_o && !io_line_two_oe_o && !io_line_three_oe_o;
    endproperty
    a_single_line: assert property (p_single_line)
        else $error("extra line driven in single transfer");

    property p_dual_both;
        @(posedge clock_i) disable iff (sys_rst_i)
        io_line_one_oe_o && (data_lanes_q == LANES_2) |->
            io_line_zero_oe_o && !io_line_three_oe_o;
    endproperty
    a_dual_both: assert property (p_dual_both)
        else $error("dual read not driving both lines");

    property p_quad_four;
        @(posedge clock_i) disable iff (sys_rst_i)
        io_line_three_oe_o |-> io_line_two_oe_o && io_line_one_oe_o &&
                               io_line_zero_oe_o && (cmd_o == OP_QUAD_IO);
    endproperty
    a_quad_four: assert property (p_quad_four)
        else $error("four-line drive outside quad read");

    property p_dual_opcode;
        @(posedge clock_i) disable iff (sys_rst_i)
        cmd_valid_o && ((cmd_o == OP_DUAL_OUT) || (cmd_o == OP_DUAL_IO)) |->
            data_lanes_q == LANES_2;
    endproperty
    a_dual_opcode: assert property (p_dual_opcode)
        else $error("dual opcode without two-line data");

    property p_index_nesting;
        @(posedge clock_i) disable iff (sys_rst_i)
        addr_valid_o |-> (sector_o[SECTOR_W-1:3] == half_block_o) &&
                         (sector_o[SECTOR_W-1:4] == block_o);
    endproperty
    a_index_nesting: assert property (p_index_nesting)
        else $error("sector and block indices disagree");

    property p_cmd_after_rise;
        @(posedge clock_i) disable iff (sys_rst_i)
        cmd_valid_o |-> $past(pin.rise) && $past(pin.sel);
    endproperty
    a_cmd_after_rise: assert property (p_cmd_after_rise)
        else $error("opcode taken without a rising clock edge");

    property p_idle_on_deselect;
        @(posedge clock_i) disable iff (sys_rst_i)
        !pin.sel |=> state_q == ST_IDLE;
    endproperty
    a_idle_on_deselect: assert property (p_idle_on_deselect)
        else $error("frame not ended by deselect");

endmodule

// *** shared/sff_pkg.sv ***
// Constants and types shared by the serial flash bus front end
package sff_pkg;

    // Opcodes
    localparam logic [7:0] OP_READ         = 8'h03;
    localparam logic [7:0] OP_FAST_READ    = 8'h0b;
    localparam logic [7:0] OP_DUAL_OUT     = 8'h3b;
    localparam logic [7:0] OP_DUAL_IO      = 8'hbb;
    localparam logic [7:0] OP_QUAD_IO      = 8'heb;

    // Phase lengths in serial clocks
    localparam logic [4:0] CMD_CLKS        = 5'h08;
    localparam logic [4:0] ADDR_CLKS_X1    = 5'h18;
    localparam logic [4:0] ADDR_CLKS_X2    = 5'h0c;
    localparam logic [4:0] ADDR_CLKS_X4    = 5'h06;
    localparam logic [4:0] DUMMY_FAST      = 5'h08;
    localparam logic [4:0] DUMMY_DUAL_IO   = 5'h04;
    localparam logic [4:0] DUMMY_QUAD_IO   = 5'h06;
    localparam logic [4:0] DUMMY_NONE      = 5'h00;

    // Output bit counter start per lane width
    localparam logic [2:0] OCNT_X1         = 3'h7;
    localparam logic [2:0] OCNT_X2         = 3'h3;
    localparam logic [2:0] OCNT_X4         = 3'h1;

    // Address field layout
    localparam int ADDR_W       = 24;
    localparam int SECTOR_LSB   = 12;
    localparam int HALF_LSB     = 15;
    localparam int BLOCK_LSB    = 16;
    localparam int RANGE_LSB    = 22;
    localparam int SECTOR_W     = RANGE_LSB - SECTOR_LSB;
    localparam int HALF_W       = RANGE_LSB - HALF_LSB;
    localparam int BLOCK_W      = RANGE_LSB - BLOCK_LSB;

    // Reset values
    localparam logic [ADDR_W-1:0] ADDR_RST = 24'h000000;
    localparam logic [7:0]        BYTE_RST = 8'h00;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_CMD   = 3'b001,
        ST_ADDR  = 3'b010,
        ST_DUMMY = 3'b011,
        ST_DATA  = 3'b100,
        ST_RX    = 3'b101
    } sff_state_t;

    typedef enum logic [2:0] {
        LANES_1 = 3'b001,
        LANES_2 = 3'b010,
        LANES_4 = 3'b100
    } sff_lanes_t;

endpackage

// *** shared/sff_pin_if.sv ***
// Sampled serial pin events passed from the pin sampler to the engine
`timescale 1ns/10ps
interface sff_pin_if;
    logic       sel;
    logic       rise;
    logic       fall;
    logic [3:0] din;

    modport sampler (output sel, output rise, output fall, output din);
    modport engine  (input sel, input rise, input fall, input din);
endinterface

// *** verilog/sff_pin_sampler.sv ***
// Samples serial clock, select and data lines and marks clock edges
`timescale 1ns/10ps
module sff_pin_sampler
    import sff_pkg::*;
(
    input  wire logic       clock_i,
    input  wire logic       sys_rst_i,
    input  wire logic       sclk_i,
    input  wire logic       cs_n_i,
    input  wire logic [3:0] din_i,
    sff_pin_if.sampler      pin
);
    import sff_pkg::*;

    logic       sclk_q;
    logic       sclk_prev_q;
    logic       cs_n_q;
    logic [3:0] din_q;

    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            sclk_q      <= sclk_i;
            sclk_prev_q <= sclk_i;
            cs_n_q      <= 1'b1;
            din_q       <= 4'h0;
        end else begin
            sclk_q      <= sclk_i;
            sclk_prev_q <= sclk_q;
            cs_n_q      <= cs_n_i;
            din_q       <= din_i;
        end
    end

    // Edges count only inside a frame; idle level of either mode gives none
    assign pin.sel  = ~cs_n_q;
    assign pin.rise = pin.sel & sclk_q & ~sclk_prev_q;
    assign pin.fall = pin.sel & ~sclk_q & sclk_prev_q;
    assign pin.din  = din_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks

    property p_no_edge_deselected;
        @(posedge clock_i) disable iff (sys_rst_i)
        pin.rise || pin.fall |-> !$past(cs_n_i) && ($past(sclk_i) != $past(sclk_i, 2));
    endproperty
    a_no_edge_deselected: assert property (p_no_edge_deselected)
        else $error("clock edge flagged without a pin edge inside a frame");

endmodule

// *** sim/sff_host_model.sv ***
// Behavioural serial bus host that frames reads for the front end
`timescale 1ns/10ps
module sff_host_model (
    input  wire logic       clock_i,
    input  wire logic [3:0] line_i,
    output logic            sclk_o,
    output logic            cs_n_o,
    output logic [3:0]      dat_o,
    output logic [3:0]      dat_oe_o
);
    logic cpol = 1'b0;

    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        dat_o = 4'h0;
        dat_oe_o = 4'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Clock parks at the mode's idle level before select falls
    task automatic open_frame(input logic m3);
        cpol = m3;
        sclk_o <= m3;
        repeat (4) @(posedge clock_i);
        cs_n_o <= 1'b0;
        repeat (4) @(posedge clock_i);
    endtask

    // n clocks on w lanes, MSB first; data set while clock low
    task automatic shift(input logic [31:0] v, input int n, input int w, input bit drv,
                         output logic [31:0] got);
        logic [3:0] m;
        logic [3:0] s;
        m = 4'((1 << w) - 1);
        got = 32'h0;
        for (int k = n - 1; k >= 0; k--) begin
            sclk_o <= 1'b0;
            dat_o <= 4'((v >> (k * w)) & 32'(m));
            dat_oe_o <= drv ? m : 4'h0;
            repeat (4) @(posedge clock_i);
            sclk_o <= 1'b1;
            repeat (4) @(posedge clock_i);
            s = (w == 1) ? {3'b000, line_i[1]} : (line_i & m);
            got = (got << w) | 32'(s);
        end
    endtask

    // Release lines, return clock to idle, raise select
    task automatic close_frame();
        sclk_o <= cpol;
        dat_oe_o <= 4'h0;
        repeat (4) @(posedge clock_i);
        cs_n_o <= 1'b1;
        repeat (8) @(posedge clock_i);
    endtask
endmodule

// *** sim/sff_front_end_bench.sv ***
// Self-checking bench for the serial flash bus front end
`timescale 1ns/10ps
module sff_front_end_bench;
    import sff_pkg::*;
    logic        clock_i = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic        tg = 1'b0;
    logic        sclk;
    logic        cs_n;
    logic [3:0]  h_o;
    logic [3:0]  h_oe;
    logic [3:0]  d_o;
    logic [3:0]  d_oe;
    logic [3:0]  oe_seen = 4'h0;
    logic [7:0]  cmd;
    logic [7:0]  rxb;
    logic [7:0]  rx_seen = 8'h00;
    logic [7:0]  rdd;
    logic [23:0] rda;
    logic [9:0]  sec;
    logic [6:0]  hb;
    logic [5:0]  blk;
    logic        cv;
    logic        rxv;
    logic        low;
    logic        av;
    logic        rs;
    int          av_n = 0;
    int          rs_n = 0;
    int          err_total = 0;
    int          check_count = 0;
    int          cv_n = 0;
    wire  [3:0]  ln = (d_oe & d_o) | (~d_oe & h_oe & h_o) | (~d_oe & ~h_oe & {4{tg}});

    always #2 clock_i = ~clock_i;
    assign rdd = rda[7:0] ^ 8'h5a;

    // Released lines wander; per-frame tallies clear as select falls
    always @(posedge clock_i) begin
        tg <= ~tg;
        oe_seen <= $fell(cs_n) ? 4'h0 : (oe_seen | d_oe);
        cv_n <= $fell(cs_n) ? 0 : cv_n + 32'(cv);
        av_n <= $fell(cs_n) ? 0 : av_n + 32'(av);
        rs_n <= $fell(cs_n) ? 0 : rs_n + 32'(rs);
        if (rxv) begin
            rx_seen <= rxb;
        end
    end

    sff_host_model sff_host_model_i (.clock_i(clock_i), .line_i(ln), .sclk_o(sclk),
        .cs_n_o(cs_n), .dat_o(h_o), .dat_oe_o(h_oe));

    sff_front_end sff_front_end_i (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .sclk_i(sclk),
        .cs_n_i(cs_n), .io_line_zero_i(ln[0]), .io_line_zero_o(d_o[0]),
        .io_line_zero_oe_o(d_oe[0]), .io_line_one_i(ln[1]), .io_line_one_o(d_o[1]),
        .io_line_one_oe_o(d_oe[1]), .io_line_two_i(ln[2]), .io_line_two_o(d_o[2]),
        .io_line_two_oe_o(d_oe[2]), .io_line_three_i(ln[3]), .io_line_three_o(d_o[3]),
        .io_line_three_oe_o(d_oe[3]), .cmd_o(cmd), .cmd_valid_o(cv), .rx_byte_o(rxb),
        .rx_valid_o(rxv), .addr_valid_o(av), .rd_addr_o(rda), .rd_strobe_o(rs),
        .rd_data_i(rdd), .sector_o(sec), .half_block_o(hb), .block_o(blk),
        .in_low_range_o(low));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic test_done();
        if (err_total == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // One read frame of two bytes, then judge data, decode and drivers
    task automatic rd_frame(input logic [7:0] op, input logic m3, input logic [23:0] a,
                            input int aw, input int dm, input int dw, input logic [3:0] oe);
        logic [31:0] g;
        logic [7:0]  nx;
        nx = a[7:0] + 8'h01;
        sff_host_model_i.open_frame(m3);
        sff_host_model_i.shift(32'(op), 8, 1, 1'b1, g);
        sff_host_model_i.shift(32'(a), 24 / aw, aw, 1'b1, g);
        sff_host_model_i.shift(32'h0, dm, 1, 1'b0, g);
        sff_host_model_i.shift(32'h0, 16 / dw, dw, 1'b0, g);
        sff_host_model_i.close_frame();
        chk("data", g, {16'h0000, a[7:0] ^ 8'h5a, nx ^ 8'h5a});
        chk("cmd", 32'(cmd), 32'(op));
        chk("cmd_pulses", 32'(cv_n), 32'h1);
        chk("addr_pulses", 32'(av_n), 32'h1);
        chk("strobes", 32'(rs_n), m3 ? 32'h2 : 32'h3);
        chk("rd_addr", 32'(rda), 32'(a + (m3 ? 24'h000002 : 24'h000003)));
        chk("sector", 32'(sec), 32'(a[21:12]));
        chk("half_block", 32'(hb), 32'(a[21:15]));
        chk("block", 32'(blk), 32'(a[21:16]));
        chk("low_range", 32'(low), 32'(a[23:22] == 2'b00));
        chk("drivers", 32'(oe_seen), 32'(oe));
        chk("idle_oe", 32'(d_oe), 32'h0);
    endtask

    task automatic t_read_m0();
        rd_frame(OP_READ, 1'b0, 24'h3ff000, 1, 0, 1, 4'h2);
    endtask

    task automatic t_fast_m3();
        rd_frame(OP_FAST_READ, 1'b1, 24'h00f000, 1, 8, 1, 4'h2);
    endtask

    task automatic t_dual_out();
        rd_frame(OP_DUAL_OUT, 1'b0, 24'h0010fe, 1, 8, 2, 4'h3);
    endtask

    task automatic t_dual_io();
        rd_frame(OP_DUAL_IO, 1'b1, 24'h400000, 2, 4, 2, 4'h3);
    endtask

    task automatic t_quad_io();
        rd_frame(OP_QUAD_IO, 1'b0, 24'hc3f0ff, 4, 6, 4, 4'hf);
    endtask

    // Unknown opcode: byte handed over, nothing driven
    task automatic t_other();
        logic [31:0] g;
        sff_host_model_i.open_frame(1'b0);
        sff_host_model_i.shift(32'h0000_06c3, 16, 1, 1'b1, g);
        sff_host_model_i.close_frame();
        chk("rx_byte", 32'(rx_seen), 32'h0000_00c3);
        chk("other_oe", 32'(oe_seen), 32'h0);
        chk("other_addr", 32'(av_n), 32'h0);
    endtask

    initial begin
        repeat (4) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        @(posedge clock_i);
        t_read_m0();
        t_fast_m3();
        t_dual_out();
        t_dual_io();
        t_quad_io();
        t_other();
        test_done();
    end

    // Whole run needs about 1900 cycles
    initial begin
        repeat (20000) @(posedge clock_i);
        err_total++;
        test_done();
    end
endmodule
